// ==== core/dcss_host.sv ====
// Purpose: host sequencer for DAC clock and power-up programming
// Assumes: software fills config registers then sets the start bit
// Notes: steps run in the fixed documented order
`timescale 1ns/100ps
`default_nettype none
module dcss_host
	import dcss_pkg::*;
#(
	parameter int SOFTSTEP_CYCLES = SOFTSTEP_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	output dcss_wr_s devWr,
	input wire logic devAck,
	output dcss_rd_s devRd,
	input wire logic [7:0] devRdData,
	input wire logic devRdValid
);
	localparam int STEP_W = 5;
	localparam int CNT_W = 32;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		dcss_state_e st;
		logic [STEP_W-1:0] step;
		logic [CNT_W-1:0] cnt;
		logic [7:0] polls;
		logic [31:0] ctrl;
		logic [31:0] divs;
		logic [31:0] osr;
		logic [31:0] pll;
		logic [31:0] mode;
		logic [31:0] analog;
		logic [31:0] rd;
		logic busy;
		logic done;
		logic err;
		logic timeout;
		logic [5:0] planErr;
		dcss_wr_s req;
		dcss_rd_s rdReq;
	} dcss_host_s;
	dcss_host_s s_q, s_d;

	logic planOk;
	logic [5:0] planErr;
	logic wrDone;
	logic stepUsed;
	dcss_wr_s stepWr;

	dcss_check u_check (
		.filterB(s_q.ctrl[CTRL_FILT_B]),
		.osr(s_q.osr[9:0]),
		.firstDiv(s_q.divs[7:0]),
		.secondDiv(s_q.divs[15:8]),
		.sampleRate(s_q.osr[32-1:15]),
		.wordLen(s_q.mode[1:0]),
		.perfMode(s_q.mode[4:2]),
		.highPerf(s_q.mode[5]),
		.resCount(s_q.mode[15:8]),
		.planOk(planOk),
		.planErr(planErr)
	);

	dcss_wr_port u_port (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.req(s_q.req),
		.devAck(devAck),
		.devWr(devWr),
		.done(wrDone)
	);

	// ---------------------------------------------------------------
	// sequence table
	// ---------------------------------------------------------------
	// one write per step; unused PLL steps are skipped
	function automatic dcss_wr_s mk(input logic [7:0] a,
		input logic [7:0] d);
		dcss_wr_s w;
		w.valid = 1'b1;
		w.addr = a;
		w.data = d;
		return w;
	endfunction

	always_comb begin
		stepUsed = 1'b1;
		stepWr = '0;
		case (s_q.step)
			5'd0: stepWr = mk(PAGE_SEL_REG, PAGE_ZERO);
			5'd1: stepWr = mk(PG0_SW_RESET, SW_RESET_VAL);
			5'd2: stepWr = mk(PG0_PLL_PR, s_q.pll[7:0] | PLL_POWER);
			5'd3: stepWr = mk(PG0_PLL_J, s_q.pll[15:8]);
			5'd4: stepWr = mk(PG0_PLL_DMSB, s_q.pll[23:16]);
			5'd5: stepWr = mk(PG0_PLL_DLSB, s_q.pll[31:24]);
			5'd6: stepWr = mk(PG0_FIRST_DIV, s_q.divs[7:0] | DIV_POWER);
			5'd7: stepWr = mk(PG0_SECOND_DIV, s_q.divs[15:8] | DIV_POWER);
			5'd8: stepWr = mk(PG0_OSR_MSB, {6'h00, s_q.osr[9:8]});
			5'd9: stepWr = mk(PG0_OSR_LSB, s_q.osr[7:0]);
			5'd10: stepWr = mk(PG0_IFACE,
				8'(32'(s_q.mode[1:0]) << WLEN_LSB));
			5'd11: stepWr = mk(PG0_PROC_BLOCK, s_q.mode[23:16]);
			5'd12: stepWr = mk(PAGE_SEL_REG, PAGE_ONE);
			5'd13: stepWr = mk(PG1_POR_CTRL,
				8'(32'(s_q.ctrl[CTRL_POR_DIS]) << POR_DIS_BIT));
			5'd14: stepWr = mk(PG1_SUPPLY, SUPPLY_COARSE_OFF);
			5'd15: stepWr = mk(PG1_SUPPLY, 8'h00);
			5'd16: stepWr = mk(PG1_PERF_MODE,
				8'(32'(s_q.mode[4:2]) << PERF_LSB));
			5'd17: stepWr = mk(PG1_COMMON_MODE, s_q.analog[7:0]);
			5'd18: stepWr = mk(PG1_ANTIPOP, s_q.analog[15:8]);
			5'd19: stepWr = mk(PG1_ROUTING, s_q.analog[23:16]);
			5'd20: stepWr = mk(PG1_HP_GAIN, s_q.analog[31:24]);
			5'd21: stepWr = mk(PG1_HP_POWER, DRV_POWER);
			5'd22: stepWr = mk(PAGE_SEL_REG, PAGE_ZERO);
			5'd23: stepWr = mk(PG0_DAC_POWER, DAC_POWER_VAL);
			5'd24: stepWr = mk(PG0_DAC_GAIN, s_q.mode[31:24]);
			5'd25: stepWr = mk(PG0_DAC_MUTE, UNMUTE_VAL);
			default: stepUsed = 1'b0;
		endcase
		if (!s_q.ctrl[CTRL_USE_PLL] && s_q.step >= 5'd2 && s_q.step <= 5'd5) begin
			stepWr.valid = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// sequencer and register port
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.req = '0;
		s_d.rdReq = '0;
		// register reads, data one cycle later
		s_d.rd = 32'h0000_0000;
		if (regRead) begin
			if (regAddr == HREG_CTRL) begin
				s_d.rd = s_q.ctrl;
			end else if (regAddr == HREG_DIVS) begin
				s_d.rd = s_q.divs;
			end else if (regAddr == HREG_OSR) begin
				s_d.rd = s_q.osr;
			end else if (regAddr == HREG_PLL) begin
				s_d.rd = s_q.pll;
			end else if (regAddr == HREG_MODE) begin
				s_d.rd = s_q.mode;
			end else if (regAddr == HREG_ANALOG) begin
				s_d.rd = s_q.analog;
			end else if (regAddr == HREG_STATUS) begin
				s_d.rd = {12'h000, 3'h0, s_q.step, 2'h0, s_q.planErr,
					s_q.timeout, s_q.err, s_q.done, s_q.busy};
			end
		end
		// config writes are ignored while busy
		if (regWrite && !s_q.busy) begin
			if (regAddr == HREG_CTRL) begin
				s_d.ctrl = regWrData;
			end else if (regAddr == HREG_DIVS) begin
				s_d.divs = regWrData;
			end else if (regAddr == HREG_OSR) begin
				s_d.osr = regWrData;
			end else if (regAddr == HREG_PLL) begin
				s_d.pll = regWrData;
			end else if (regAddr == HREG_MODE) begin
				s_d.mode = regWrData;
			end else if (regAddr == HREG_ANALOG) begin
				s_d.analog = regWrData;
			end
		end
		case (s_q.st)
			ST_IDLE: begin
				if (s_q.ctrl[CTRL_START]) begin
					s_d.ctrl[CTRL_START] = 1'b0;
					s_d.st = ST_CHECK;
					s_d.busy = 1'b1;
					s_d.done = 1'b0;
					s_d.err = 1'b0;
					s_d.timeout = 1'b0;
					s_d.step = '0;
				end
			end
			ST_CHECK: begin
				s_d.planErr = planErr;
				s_d.st = planOk ? ST_WRITE : ST_ERR;
			end
			ST_WRITE: begin
				if (!stepUsed) begin
					s_d.st = ST_DONE;
				end else if (!stepWr.valid) begin
					s_d.step = s_q.step + 5'd1;
				end else begin
					s_d.req = stepWr;
					s_d.st = ST_WAITWR;
				end
			end
			ST_WAITWR: begin
				if (wrDone) begin
					s_d.step = s_q.step + 5'd1;
					s_d.cnt = '0;
					s_d.polls = '0;
					// after drivers power up, wait or poll
					if (s_q.step == 5'd21) begin
						s_d.st = s_q.ctrl[CTRL_POLL] ? ST_POLL : ST_SOFT;
					end else begin
						s_d.st = ST_WRITE;
					end
				end
			end
			ST_SOFT: begin
				s_d.cnt = s_q.cnt + 32'd1;
				if (s_q.cnt == CNT_W'(SOFTSTEP_CYCLES - 1)) begin
					s_d.st = ST_WRITE;
				end
			end
			ST_POLL: begin
				s_d.rdReq.rdStrobe = 1'b1;
				s_d.rdReq.addr = PG1_GAIN_STATUS;
				s_d.st = ST_POLLW;
			end
			ST_POLLW: begin
				if (devRdValid) begin
					if ((devRdData & GAIN_DONE_MASK) != 8'h00) begin
						s_d.st = ST_WRITE;
					end else if (s_q.polls == 8'(POLL_LIMIT)) begin
						s_d.timeout = 1'b1;
						s_d.st = ST_ERR;
					end else begin
						s_d.polls = s_q.polls + 8'd1;
						s_d.st = ST_POLL;
					end
				end
			end
			ST_DONE: begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.st = ST_IDLE;
			end
			ST_ERR: begin
				s_d.busy = 1'b0;
				s_d.err = 1'b1;
				s_d.st = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rd;
	assign devRd = s_q.rdReq;
endmodule
`default_nettype wire

// ==== core/dcss_pkg.sv ====
// Purpose: constants and types for the DAC clock setup sequencer (host side)
// Assumes: device reached through a byte-wide paged register write port
// Notes: the sequencer replays the documented power-up order
package dcss_pkg;
	// device register addresses (page, register)
	localparam logic [7:0] PAGE_SEL_REG = 8'h00;
	localparam logic [7:0] PG0_SW_RESET = 8'h01;
	localparam logic [7:0] PG0_PLL_PR = 8'h05;
	localparam logic [7:0] PG0_PLL_J = 8'h06;
	localparam logic [7:0] PG0_PLL_DMSB = 8'h07;
	localparam logic [7:0] PG0_PLL_DLSB = 8'h08;
	localparam logic [7:0] PG0_FIRST_DIV = 8'h0B;
	localparam logic [7:0] PG0_SECOND_DIV = 8'h0C;
	localparam logic [7:0] PG0_OSR_MSB = 8'h0D;
	localparam logic [7:0] PG0_OSR_LSB = 8'h0E;
	localparam logic [7:0] PG0_IFACE = 8'h1B;
	localparam logic [7:0] PG0_PROC_BLOCK = 8'h3C;
	localparam logic [7:0] PG0_DAC_POWER = 8'h3F;
	localparam logic [7:0] PG0_DAC_GAIN = 8'h41;
	localparam logic [7:0] PG0_DAC_MUTE = 8'h40;
	localparam logic [7:0] PG1_POR_CTRL = 8'h01;
	localparam logic [7:0] PG1_SUPPLY = 8'h02;
	localparam logic [7:0] PG1_PERF_MODE = 8'h03;
	localparam logic [7:0] PG1_COMMON_MODE = 8'h0A;
	localparam logic [7:0] PG1_ROUTING = 8'h0C;
	localparam logic [7:0] PG1_HP_GAIN = 8'h10;
	localparam logic [7:0] PG1_HP_POWER = 8'h09;
	localparam logic [7:0] PG1_ANTIPOP = 8'h14;
	localparam logic [7:0] PG1_GAIN_STATUS = 8'h3F;
	// field positions and values
	localparam int POR_DIS_BIT = 3;
	localparam int PERF_LSB = 2;
	localparam int WLEN_LSB = 4;
	localparam logic [7:0] SW_RESET_VAL = 8'h01;
	localparam logic [7:0] DIV_POWER = 8'h80;
	localparam logic [7:0] PLL_POWER = 8'h80;
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] PAGE_ONE = 8'h01;
	localparam logic [7:0] DRV_POWER = 8'h20;
	localparam logic [7:0] DAC_POWER_VAL = 8'h80;
	localparam logic [7:0] UNMUTE_VAL = 8'h00;
	localparam logic [7:0] SUPPLY_COARSE_OFF = 8'h08;
	localparam logic [7:0] GAIN_DONE_MASK = 8'h20;
	localparam logic [2:0] PERF_ONE = 3'h2;
	localparam logic [2:0] PERF_TWO = 3'h1;
	localparam logic [2:0] PERF_HIGH = 3'h0;
	localparam logic [1:0] WLEN_16 = 2'h0;
	localparam logic [1:0] WLEN_20 = 2'h1;
	localparam logic [1:0] WLEN_24 = 2'h2;
	localparam logic [1:0] WLEN_32 = 2'h3;
	localparam logic [7:0] DIV_MAX = 8'h80;
	localparam logic [7:0] DIV_MIN = 8'h01;
	localparam int RATIO_DIV = 32;
	// host register map
	localparam logic [3:0] HREG_CTRL = 4'h0;
	localparam logic [3:0] HREG_DIVS = 4'h1;
	localparam logic [3:0] HREG_OSR = 4'h2;
	localparam logic [3:0] HREG_PLL = 4'h3;
	localparam logic [3:0] HREG_MODE = 4'h4;
	localparam logic [3:0] HREG_ANALOG = 4'h5;
	localparam logic [3:0] HREG_STATUS = 4'h6;
	localparam logic [3:0] HREG_WAIT = 4'h7;
	// control bits in HREG_CTRL
	localparam int CTRL_START = 0;
	localparam int CTRL_USE_PLL = 1;
	localparam int CTRL_POLL = 2;
	localparam int CTRL_POR_DIS = 3;
	localparam int CTRL_FILT_B = 4;
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SOFTSTEP_US = 1000;
	localparam int SOFTSTEP_CYC = SOFTSTEP_US * (CLK_HZ / 1_000_000);
	localparam int POLL_LIMIT = 255;

	// one device write request
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} dcss_wr_s;

	// bus with a read answer
	typedef struct packed {
		logic rdStrobe;
		logic [7:0] addr;
	} dcss_rd_s;

	// one-hot sequence states
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_WRITE = 10'h002,
		ST_WAITWR = 10'h004,
		ST_SOFT = 10'h008,
		ST_POLL = 10'h010,
		ST_POLLW = 10'h020,
		ST_DONE = 10'h040,
		ST_ERR = 10'h080,
		ST_CHECK = 10'h100,
		ST_SPARE = 10'h200
	} dcss_state_e;
endpackage

// ==== core/dcss_check.sv ====
// Purpose: validates the programmed clock plan before any device write
// Assumes: rate given in Hz, ratio and dividers as plain integers
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module dcss_check
	import dcss_pkg::*;
#(
	parameter int RATE_W = 17
) (
	input wire logic filterB,
	input wire logic [9:0] osr,
	input wire logic [7:0] firstDiv,
	input wire logic [7:0] secondDiv,
	input wire logic [RATE_W-1:0] sampleRate,
	input wire logic [1:0] wordLen,
	input wire logic [2:0] perfMode,
	input wire logic highPerf,
	input wire logic [7:0] resCount,
	output logic planOk,
	output logic [5:0] planErr
);
	// ratio times rate, wide enough for 1023 * 131071
	logic [31:0] osrRate;
	logic [31:0] resTerm;

	// legal divider range check
	function automatic logic divOk(input logic [7:0] d);
		return (d >= DIV_MIN) && (d <= DIV_MAX);
	endfunction

	always_comb begin
		osrRate = 32'(osr) * 32'(sampleRate);
		resTerm = (32'(secondDiv) * 32'(osr)) / 32'(RATIO_DIV);
		planErr[0] = filterB ? (osr[1:0] != 2'h0) : (osr[2:0] != 3'h0);
		planErr[1] = !((osrRate > 32'd2_800_000) && (osrRate < 32'd6_200_000));
		planErr[2] = !(divOk(firstDiv) && divOk(secondDiv));
		planErr[3] = resTerm < 32'(resCount);
		planErr[4] = highPerf && (wordLen == WLEN_16);
		planErr[5] = highPerf && (perfMode != PERF_HIGH);
		planOk = (planErr == 6'h00);
	end
endmodule
`default_nettype wire

// ==== core/dcss_wr_port.sv ====
// Purpose: hands one device write out and waits for its acknowledge
// Assumes: device port acknowledges each write with devAck
// Notes: holds the request stable until acknowledged
`timescale 1ns/100ps
`default_nettype none
module dcss_wr_port
	import dcss_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire dcss_wr_s req,
	input wire logic devAck,
	output dcss_wr_s devWr,
	output logic done
);
	typedef struct packed {
		dcss_wr_s wr;
		logic done;
	} dcss_port_s;
	dcss_port_s s_q, s_d;

	// latch request, drop it on acknowledge
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (s_q.wr.valid) begin
			if (devAck) begin
				s_d.wr.valid = 1'b0;
				s_d.done = 1'b1;
			end
		end else if (req.valid) begin
			s_d.wr = req;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign devWr = s_q.wr;
	assign done = s_q.done;
endmodule
`default_nettype wire

// ==== sim/dcss_host_sva.sv ====
// Purpose: port checks for dcss_host
// Assumes: one clock, synchronous reset
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module dcss_host_sva
	import dcss_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	input wire dcss_wr_s devWr,
	input wire logic devAck,
	input wire dcss_rd_s devRd
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [1:0] acks_q;
	// counts device acknowledges since reset, stopping at 3
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			acks_q <= 2'h0;
		else if (devWr.valid && devAck && acks_q != 2'h3)
			acks_q <= acks_q + 2'h1;
	end
	sequence s_ack;
		devWr.valid && devAck;
	endsequence
	sequence s_gap;
		!devWr.valid [*2];
	endsequence
	sequence s_swReset;
		devWr.valid && devWr.addr == PG0_SW_RESET && devWr.data == SW_RESET_VAL;
	endsequence
	property p_rdZero;
		!$past(regRead) |-> regRdData == 32'h0;
	endproperty
	a_rdZero: assert property (p_rdZero) else $error("read data off cycle");
	property p_wrHold;
		devWr.valid && !devAck |=> devWr.valid && $stable(devWr);
	endproperty
	a_wrHold: assert property (p_wrHold) else $error("write moved");
	property p_wrGap;
		s_ack |=> s_gap;
	endproperty
	a_wrGap: assert property (p_wrGap) else $error("write gap short");
	property p_pageFirst;
		acks_q == 2'h0 && devWr.valid |->
			devWr.addr == PAGE_SEL_REG && devWr.data == PAGE_ZERO;
	endproperty
	a_pageFirst: assert property (p_pageFirst) else $error("first write");
	property p_resetNext;
		acks_q == 2'h0 ##0 s_ack |=> s_gap ##[1:20] s_swReset;
	endproperty
	a_resetNext: assert property (p_resetNext) else $error("no reset");
	property p_rdPulse;
		devRd.rdStrobe |=> !devRd.rdStrobe;
	endproperty
	a_rdPulse: assert property (p_rdPulse) else $error("poll too long");
	property p_rdAddr;
		devRd.rdStrobe |-> devRd.addr == PG1_GAIN_STATUS;
	endproperty
	a_rdAddr: assert property (p_rdAddr) else $error("poll address");
	property p_noMix;
		devRd.rdStrobe |-> !devWr.valid;
	endproperty
	a_noMix: assert property (p_noMix) else $error("poll during write");
endmodule
bind dcss_host dcss_host_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.regRead(regRead), .regRdData(regRdData), .devWr(devWr),
	.devAck(devAck), .devRd(devRd));
`default_nettype wire

// ==== sim/dcss_dev_model.sv ====
// Purpose: paged register device seen by the sequencer
// Assumes: one write or one poll at a time
// Notes: logs each accepted write with its cycle
`timescale 1ns/100ps
`default_nettype none
module dcss_dev_model
	import dcss_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire dcss_wr_s devWr,
	output logic devAck,
	input wire dcss_rd_s devRd,
	output logic [7:0] devRdData,
	output logic devRdValid,
	input wire logic [3:0] ackWait,
	input wire logic [3:0] busyPolls
);
	logic [7:0] pg0 [256];
	logic [7:0] pg1 [256];
	logic [48:0] wlog [$];
	logic page = 1'b0;
	logic porOff = 1'b0;
	logic [3:0] waitCnt = 4'h0;
	logic [3:0] polls = 4'h0;
	logic [31:0] cyc = 32'h0;
	initial devAck = 1'b0;
	initial devRdValid = 1'b0;
	initial devRdData = 8'h5A;
	// registers back to defaults
	task clr();
		for (int k = 0; k < 256; k++) begin
			pg0[k] = 8'h00;
			pg1[k] = 8'h00;
		end
	endtask
	initial clr();
	// sample strobe counters and the measured strobe period
	logic fsTick = 1'b0;
	int nCnt = 0, mCnt = 0, oCnt = 0, sinceTick = 0, lastGap = 0;
	// divider value, code zero standing for the top count
	function automatic int divVal(input logic [7:0] r);
		return (r[6:0] == 7'h00) ? 128 : int'(r[6:0]);
	endfunction
	// first divider, second divider and ratio counters in cascade
	always @(posedge clk_sys) begin
		fsTick <= 1'b0;
		sinceTick <= sinceTick + 1;
		if (!pg0[PG0_FIRST_DIV][7] || !pg0[PG0_SECOND_DIV][7]) begin
			nCnt <= 0;
			mCnt <= 0;
			oCnt <= 0;
		end else if (nCnt < divVal(pg0[PG0_FIRST_DIV]) - 1) begin
			nCnt <= nCnt + 1;
		end else if (mCnt < divVal(pg0[PG0_SECOND_DIV]) - 1) begin
			nCnt <= 0;
			mCnt <= mCnt + 1;
		end else if (oCnt <
			int'({pg0[PG0_OSR_MSB][1:0], pg0[PG0_OSR_LSB]}) - 1) begin
			nCnt <= 0;
			mCnt <= 0;
			oCnt <= oCnt + 1;
		end else begin
			nCnt <= 0;
			mCnt <= 0;
			oCnt <= 0;
			fsTick <= 1'b1;
			lastGap <= sinceTick + 1;
			sinceTick <= 0;
		end
	end
	// acks writes after ackWait cycles, answers polls
	always @(posedge clk_sys) begin
		cyc <= cyc + 32'h1;
		devAck <= 1'b0;
		devRdValid <= 1'b0;
		devRdData <= ~devRdData; // idle bus toggles
		if (sys_rst) begin
			if (!porOff) clr();
			waitCnt <= 4'h0;
			polls <= 4'h0;
		end else if (devWr.valid && !devAck) begin
			if (waitCnt == ackWait) begin
				devAck <= 1'b1;
				waitCnt <= 4'h0;
				wlog.push_back({cyc, page, devWr.addr, devWr.data});
				if (devWr.addr == PAGE_SEL_REG)
					page <= devWr.data[0];
				else if (!page && devWr.addr == PG0_SW_RESET && devWr.data[0])
					clr();
				else if (page)
					pg1[devWr.addr] = devWr.data;
				else
					pg0[devWr.addr] = devWr.data;
				if (page && devWr.addr == PG1_POR_CTRL)
					porOff <= devWr.data[POR_DIS_BIT];
			end else
				waitCnt <= waitCnt + 4'h1;
		end
		if (!sys_rst && devRd.rdStrobe) begin
			polls <= polls + 4'h1;
			devRdValid <= 1'b1;
			devRdData <= (polls >= busyPolls) ? GAIN_DONE_MASK : 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== sim/dcss_host_test.sv ====
// Purpose: self-checking bench for dcss_host
// Assumes: device model on the far side
// Notes: soft-step time shortened to SS cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	failures++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module dcss_host_test;
	import dcss_pkg::*;
	localparam int SS = 10;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData;
	dcss_wr_s devWr;
	dcss_rd_s devRd;
	logic devAck, devRdValid;
	logic [7:0] devRdData;
	logic [3:0] ackWait = 4'h0;
	logic [3:0] busyPolls = 4'h3;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	dcss_host #(.SOFTSTEP_CYCLES(SS)) DUT (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.devWr(devWr), .devAck(devAck), .devRd(devRd),
		.devRdData(devRdData), .devRdValid(devRdValid));
	dcss_dev_model DEV (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.devWr(devWr), .devAck(devAck), .devRd(devRd),
		.devRdData(devRdData), .devRdValid(devRdValid),
		.ackWait(ackWait), .busyPolls(busyPolls));
	always #20 clk_sys = ~clk_sys;
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		if (failures == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task rst1();
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		DEV.wlog.delete();
	endtask
	task waitEnd(output logic [31:0] s);
		for (int k = 0; k < 3000; k++) begin
			rd(HREG_STATUS, s);
			if (s[1] | s[2]) break;
		end
	endtask
	function int pos(logic pg, logic [7:0] a);
		foreach (DEV.wlog[k])
			if (DEV.wlog[k][16:8] == {pg, a}) return k;
		return 999;
	endfunction
	// main sequence
	initial begin
		logic [31:0] s, osrW, divW, modeW, ctlW;
		logic [2:0] perf;
		logic [5:0] pe;
		int n;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(HREG_STATUS, s);
		`CHK("status", 32'h0, s)
		rd(4'hF, s);
		`CHK("unmapped", 32'h0, s)
		for (int i = 0; i < 4; i++) begin
			rst1();
			ackWait <= (i == 3) ? 4'h3 : 4'h0;
			perf = (i == 0) ? PERF_ONE : (i == 1) ? PERF_TWO : PERF_HIGH;
			wr(HREG_DIVS, 32'h0000_0204);
			wr(HREG_OSR, (i == 3) ? {17'h07D00, 5'h0, 10'h080}
				: {17'h0BB80, 5'h0, 10'h040});
			wr(HREG_PLL, 32'h0104_0201);
			wr(HREG_MODE, {16'h0002, 8'h04, 2'h0, i > 1, perf, 2'(i)});
			wr(HREG_ANALOG, 32'h0203_0100);
			wr(HREG_CTRL, {27'h0, i == 3, i[0], i == 3, i == 3, 1'b1});
			waitEnd(s);
			`CHK("done", 32'h2, s & 32'hF)
			`CHK("page0", {PAGE_SEL_REG, PAGE_ZERO}, DEV.wlog[0][15:0])
			`CHK("swreset", {1'b0, PG0_SW_RESET}, DEV.wlog[1][16:8])
			`CHK("divs", 1'b1, pos(0, PG0_FIRST_DIV) < pos(0, PG0_SECOND_DIV))
			`CHK("osr", 1'b1, pos(0, PG0_SECOND_DIV) < pos(0, PG0_OSR_LSB))
			`CHK("block", 1'b1, pos(0, PG0_OSR_MSB) < pos(0, PG0_PROC_BLOCK))
			if (i == 3)
				`CHK("pll", 1'b1, pos(0, PG0_PLL_PR) < pos(0, PG0_FIRST_DIV))
			n = pos(1, PG1_SUPPLY);
			`CHK("coarse", SUPPLY_COARSE_OFF, DEV.wlog[n][7:0])
			`CHK("analog", 8'h00, DEV.pg1[PG1_SUPPLY])
			n = pos(1, PG1_HP_POWER);
			`CHK("drv", 1'b1, pos(1, PG1_HP_GAIN) < n && pos(1, PG1_ROUTING) < n
				&& pos(1, PG1_COMMON_MODE) < n)
			if (i < 3)
				`CHK("wait", 1'b1, DEV.wlog[n+1][48:17] - DEV.wlog[n][48:17] >= SS)
			else
				`CHK("polls", 4'h4, DEV.polls)
			`CHK("dac", 1'b1, n < pos(0, PG0_DAC_POWER))
			`CHK("unmute", {1'b0, PG0_DAC_MUTE, UNMUTE_VAL}, DEV.wlog[$][16:0])
			`CHK("por", i[0], DEV.pg1[PG1_POR_CTRL][POR_DIS_BIT])
			`CHK("perf", perf, DEV.pg1[PG1_PERF_MODE][4:2])
			`CHK("wlen", 2'(i), DEV.pg0[PG0_IFACE][5:4])
			`CHK("divpwr", 1'b1, DEV.pg0[PG0_FIRST_DIV][7])
			// second strobe after setup spans one whole period
			repeat (2) @(posedge DEV.fsTick);
			@(posedge clk_sys);
			`CHK("fs", 4 * 2 * ((i == 3) ? 128 : 64), DEV.lastGap)
		end
		// plans that must be refused
		for (int j = 0; j < 9; j++) begin
			rst1();
			osrW = {17'h0BB80, 5'h0, 10'h040};
			divW = 32'h0000_0204;
			modeW = 32'h0002_0400;
			ctlW = 32'h1;
			case (j)
				0: begin
					osrW[9:0] = 10'h03C;
					divW[15:8] = 8'h04;
					pe = 6'h01;
				end
				1: begin
					osrW[9:0] = 10'h03E;
					divW[15:8] = 8'h04;
					ctlW[4] = 1'b1;
					pe = 6'h01;
				end
				2: begin
					osrW[31:15] = 17'h0AAE6;
					pe = 6'h02;
				end
				3: begin
					osrW[31:15] = 17'h17A6B;
					pe = 6'h02;
				end
				4: begin
					divW[7:0] = 8'h00;
					pe = 6'h04;
				end
				5: begin
					divW[7:0] = 8'h81;
					pe = 6'h04;
				end
				6: begin
					modeW[15:8] = 8'h05;
					pe = 6'h08;
				end
				7: begin
					modeW[5] = 1'b1;
					pe = 6'h10;
				end
				default: begin
					modeW[5:0] = {1'b1, PERF_ONE, WLEN_20};
					pe = 6'h20;
				end
			endcase
			wr(HREG_DIVS, divW);
			wr(HREG_OSR, osrW);
			wr(HREG_MODE, modeW);
			wr(HREG_CTRL, ctlW);
			waitEnd(s);
			`CHK("refused", 1'b1, s[2])
			`CHK("plan err", pe, s[9:4])
			`CHK("no writes", 0, DEV.wlog.size())
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
